// *** common/csbx_pkg.sv ***
package csbx_pkg;

    localparam int DATA_W = 8;
    localparam int BIT_SEL_W = 3;
    localparam int NIB_W = 4;
    localparam int MSB = 7;
    localparam int NIB_MSB = 3;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    // Cycles taken by a skip instruction, the dummy slot included
    localparam logic [1:0] SKIP_CYCLES = 2'h2;

    typedef enum logic [4:0] {
        CSBX_OP_NOP = 5'h00,
        CSBX_OP_RRC_ACC = 5'h01,
        CSBX_OP_SUB_BORROW = 5'h02,
        CSBX_OP_SUB_BORROW_MEM = 5'h03,
        CSBX_OP_SUB = 5'h04,
        CSBX_OP_SUB_MEM = 5'h05,
        CSBX_OP_DEC_SKIP = 5'h06,
        CSBX_OP_DEC_SKIP_ACC = 5'h07,
        CSBX_OP_INC_SKIP = 5'h08,
        CSBX_OP_INC_SKIP_ACC = 5'h09,
        CSBX_OP_SET_BYTE = 5'h0A,
        CSBX_OP_SET_BIT = 5'h0B,
        CSBX_OP_SKIP_NZ = 5'h0C,
        CSBX_OP_SKIP_NZ_BIT = 5'h0D,
        CSBX_OP_SWAP = 5'h0E,
        CSBX_OP_SWAP_ACC = 5'h0F,
        CSBX_OP_SKIP_Z = 5'h10,
        CSBX_OP_SKIP_Z_MOVE = 5'h11,
        CSBX_OP_SKIP_Z_BIT = 5'h12
    } csbx_op_e;

    typedef struct packed {
        logic carry;
        logic zero;
        logic aux_carry_flag;
        logic overflow_flag;
        logic signed_carry_flag;
        logic carry_zero_flag;
    } csbx_flags_s;

    typedef struct packed {
        csbx_op_e op;
        logic use_imm;
        logic [7:0] imm;
        logic [2:0] bit_sel;
    } csbx_instr_s;

    typedef enum logic [1:0] {
        CSBX_ST_EXEC = 2'b01,
        CSBX_ST_DUMMY = 2'b10
    } csbx_state_e;

endpackage

// *** verilog/csbx_subtractor.sv ***
`timescale 1ns/100ps
`default_nettype none
module csbx_subtractor (
    input wire logic [7:0] minuend_i, // Accumulator
    input wire logic [7:0] subtrahend_i, // Memory byte or immediate
    input wire logic borrow_in_i, // High when a borrow is pulled in
    input wire logic old_zero_i, // Zero flag before the operation
    input wire logic chain_i, // High for borrow-chained form
    output logic [7:0] diff_o, // Result byte
    output csbx_pkg::csbx_flags_s flags_o // Flags from the result
);
    logic [8:0] full;
    logic [4:0] low;
    logic [8:0] sext;

    always_comb begin
        full = {1'b0, minuend_i} - {1'b0, subtrahend_i} - {8'h00, borrow_in_i};
        low = {1'b0, minuend_i[csbx_pkg::NIB_MSB:0]}
            - {1'b0, subtrahend_i[csbx_pkg::NIB_MSB:0]} - {4'h0, borrow_in_i};
        sext = {minuend_i[csbx_pkg::MSB], minuend_i}
            - {subtrahend_i[csbx_pkg::MSB], subtrahend_i} - {8'h00, borrow_in_i};
        diff_o = full[csbx_pkg::MSB:0];
        flags_o.carry = ~full[csbx_pkg::DATA_W];
        flags_o.zero = (full[csbx_pkg::MSB:0] == csbx_pkg::BYTE_ZERO);
        flags_o.aux_carry_flag = ~low[csbx_pkg::NIB_W];
        flags_o.overflow_flag = sext[csbx_pkg::DATA_W] ^ sext[csbx_pkg::MSB];
        // Sign of the true result, overflow corrected
        flags_o.signed_carry_flag = sext[csbx_pkg::DATA_W];
        // Chained zero keeps multi-byte results honest
        flags_o.carry_zero_flag = chain_i ? (flags_o.zero & old_zero_i) : flags_o.zero;
    end
endmodule // csbx_subtractor
`default_nettype wire

// *** verilog/csbx_bitops.sv ***
`timescale 1ns/100ps
`default_nettype none
module csbx_bitops (
    input wire logic [7:0] mem_i, // Memory byte
    input wire logic carry_i, // Carry flag
    input wire logic [2:0] bit_sel_i, // Selected bit
    output logic [7:0] rrc_o, // Rotate right through carry
    output logic rrc_carry_o, // Carry out of the rotate
    output logic [7:0] swap_o, // Nibble swap
    output logic [7:0] set_bit_o, // Byte with selected bit set
    output logic bit_val_o // Selected bit value
);
    function automatic logic [7:0] bit_mask(input logic [2:0] sel);
        bit_mask = csbx_pkg::BYTE_ONE << sel;
    endfunction

    always_comb begin
        rrc_o = {carry_i, mem_i[csbx_pkg::MSB:1]};
        rrc_carry_o = mem_i[0];
        swap_o = {mem_i[csbx_pkg::NIB_MSB:0], mem_i[csbx_pkg::MSB:csbx_pkg::NIB_W]};
        set_bit_o = mem_i | bit_mask(bit_sel_i);
        bit_val_o = |(mem_i & bit_mask(bit_sel_i));
    end
endmodule // csbx_bitops
`default_nettype wire

// *** verilog/csbx_exec.sv ***
// Function
// - Rotate memory right through carry into accumulator; memory kept, carry only.
// - Subtract with borrow: acc minus operand minus inverted carry.
// - After subtraction carry is cleared if negative, set otherwise.
// - All subtracts update overflow, zero, aux, carry, signed and carry-zero flags.
// - Plain subtract ignores carry; result to accumulator or memory.
// - Decrement memory, write back, skip when zero; no flags change.
// - Accumulator forms of dec/inc skip write accumulator, memory kept.
// - Increment memory, write back, skip when wrapped to zero; no flags.
// - Conditional skip instructions that skip take two cycles with a dummy slot; otherwise one.
// - Set byte writes all ones, flags untouched.
// - Set bit forces only selected bit to one.
// - Skip if byte, or selected bit, is nonzero; nothing modified.
// - Nibble swap to memory, or to accumulator leaving memory.
// - Skip if memory byte equals zero.
// - Copy memory to accumulator, skip when zero, no flags.
// - Bit test skips when the selected bit is zero.
`timescale 1ns/100ps
`default_nettype none
module csbx_exec (
    input wire logic mclk_i, // Instruction clock
    input wire logic reset_i, // Synchronous reset, active high
    input wire logic issue_i, // Instruction valid this cycle
    input wire csbx_pkg::csbx_instr_s instr_i, // Decoded instruction
    input wire logic [7:0] mem_rd_i, // Addressed memory byte
    output logic [7:0] acc_o, // Accumulator
    output csbx_pkg::csbx_flags_s flags_o, // Status flags
    output logic mem_we_o, // Memory write strobe
    output logic [7:0] mem_wd_o, // Memory write data
    output logic skip_o, // Next instruction is skipped
    output logic busy_o // Dummy slot in progress
);
    logic [7:0] acc_q, acc_d;
    csbx_pkg::csbx_flags_s flags_q, flags_d;
    logic mem_we_q, mem_we_d;
    logic [7:0] mem_wd_q, mem_wd_d;
    logic skip_q, skip_d;
    csbx_pkg::csbx_state_e state_q, state_d;

    logic [7:0] sub_b, diff;
    logic sub_borrow, sub_chain;
    csbx_pkg::csbx_flags_s sub_flags;
    logic [7:0] rrc, swp, setb, dec_v, inc_v;
    logic rrc_c, bitv, accepted;

    always_comb begin
        sub_b = instr_i.use_imm ? instr_i.imm : mem_rd_i;
        sub_chain = (instr_i.op == csbx_pkg::CSBX_OP_SUB_BORROW)
            || (instr_i.op == csbx_pkg::CSBX_OP_SUB_BORROW_MEM);
        sub_borrow = sub_chain & ~flags_q.carry;
        dec_v = mem_rd_i - csbx_pkg::BYTE_ONE;
        inc_v = mem_rd_i + csbx_pkg::BYTE_ONE;
        // New instructions are not taken during the dummy slot
        accepted = issue_i && (state_q == csbx_pkg::CSBX_ST_EXEC);
    end

    csbx_subtractor u_sub (
        .minuend_i(acc_q),
        .subtrahend_i(sub_b),
        .borrow_in_i(sub_borrow),
        .old_zero_i(flags_q.zero),
        .chain_i(sub_chain),
        .diff_o(diff),
        .flags_o(sub_flags)
    );

    csbx_bitops u_bit (
        .mem_i(mem_rd_i),
        .carry_i(flags_q.carry),
        .bit_sel_i(instr_i.bit_sel),
        .rrc_o(rrc),
        .rrc_carry_o(rrc_c),
        .swap_o(swp),
        .set_bit_o(setb),
        .bit_val_o(bitv)
    );

    always_comb begin
        acc_d = acc_q;
        flags_d = flags_q;
        mem_we_d = 1'b0;
        mem_wd_d = mem_wd_q;
        skip_d = 1'b0;
        state_d = state_q;
        case (state_q)
            csbx_pkg::CSBX_ST_DUMMY: begin
                state_d = csbx_pkg::CSBX_ST_EXEC;
            end
            default: begin
                if (accepted) begin
                    case (instr_i.op)
                        csbx_pkg::CSBX_OP_RRC_ACC: begin
                            acc_d = rrc;
                            flags_d.carry = rrc_c;
                        end
                        csbx_pkg::CSBX_OP_SUB_BORROW,
                        csbx_pkg::CSBX_OP_SUB: begin
                            acc_d = diff;
                            flags_d = sub_flags;
                        end
                        csbx_pkg::CSBX_OP_SUB_BORROW_MEM,
                        csbx_pkg::CSBX_OP_SUB_MEM: begin
                            mem_we_d = 1'b1;
                            mem_wd_d = diff;
                            flags_d = sub_flags;
                        end
                        csbx_pkg::CSBX_OP_DEC_SKIP: begin
                            mem_we_d = 1'b1;
                            mem_wd_d = dec_v;
                            skip_d = (dec_v == csbx_pkg::BYTE_ZERO);
                        end
                        csbx_pkg::CSBX_OP_DEC_SKIP_ACC: begin
                            acc_d = dec_v;
                            skip_d = (dec_v == csbx_pkg::BYTE_ZERO);
                        end
                        csbx_pkg::CSBX_OP_INC_SKIP: begin
                            mem_we_d = 1'b1;
                            mem_wd_d = inc_v;
                            skip_d = (inc_v == csbx_pkg::BYTE_ZERO);
                        end
                        csbx_pkg::CSBX_OP_INC_SKIP_ACC: begin
                            acc_d = inc_v;
                            skip_d = (inc_v == csbx_pkg::BYTE_ZERO);
                        end
                        csbx_pkg::CSBX_OP_SET_BYTE: begin
                            mem_we_d = 1'b1;
                            mem_wd_d = csbx_pkg::BYTE_ONES;
                        end
                        csbx_pkg::CSBX_OP_SET_BIT: begin
                            mem_we_d = 1'b1;
                            mem_wd_d = setb;
                        end
                        csbx_pkg::CSBX_OP_SKIP_NZ: begin
                            skip_d = (mem_rd_i != csbx_pkg::BYTE_ZERO);
                        end
                        csbx_pkg::CSBX_OP_SKIP_NZ_BIT: begin
                            skip_d = bitv;
                        end
                        csbx_pkg::CSBX_OP_SWAP: begin
                            mem_we_d = 1'b1;
                            mem_wd_d = swp;
                        end
                        csbx_pkg::CSBX_OP_SWAP_ACC: begin
                            acc_d = swp;
                        end
                        csbx_pkg::CSBX_OP_SKIP_Z: begin
                            skip_d = (mem_rd_i == csbx_pkg::BYTE_ZERO);
                        end
                        csbx_pkg::CSBX_OP_SKIP_Z_MOVE: begin
                            acc_d = mem_rd_i;
                            skip_d = (mem_rd_i == csbx_pkg::BYTE_ZERO);
                        end
                        csbx_pkg::CSBX_OP_SKIP_Z_BIT: begin
                            skip_d = ~bitv;
                        end
                        default: begin
                            acc_d = acc_q;
                        end
                    endcase
                    if (skip_d) begin
                        state_d = csbx_pkg::CSBX_ST_DUMMY;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            acc_q <= csbx_pkg::BYTE_ZERO;
            flags_q <= '0;
            mem_we_q <= 1'b0;
            mem_wd_q <= csbx_pkg::BYTE_ZERO;
            skip_q <= 1'b0;
            state_q <= csbx_pkg::CSBX_ST_EXEC;
        end else begin
            acc_q <= acc_d;
            flags_q <= flags_d;
            mem_we_q <= mem_we_d;
            mem_wd_q <= mem_wd_d;
            skip_q <= skip_d;
            state_q <= state_d;
        end
    end

    always_comb begin
        acc_o = acc_q;
        flags_o = flags_q;
        mem_we_o = mem_we_q;
        mem_wd_o = mem_wd_q;
        skip_o = skip_q;
        busy_o = (state_q == csbx_pkg::CSBX_ST_DUMMY);
    end
endmodule // csbx_exec
`default_nettype wire

// *** verif/csbx_exec_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module csbx_exec_chk (
    input wire logic mclk_i, // Clock
    input wire logic reset_i, // Reset
    input wire logic issue_i, // Issue
    input wire csbx_pkg::csbx_instr_s instr_i, // Instruction
    input wire logic [7:0] mem_rd_i, // Memory byte
    input wire logic [7:0] acc_o, // Accumulator
    input wire csbx_pkg::csbx_flags_s flags_o, // Flags
    input wire logic mem_we_o, // Write strobe
    input wire logic [7:0] mem_wd_o, // Write data
    input wire logic skip_o, // Skip
    input wire logic busy_o // Dummy slot
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // Issue ignored during the dummy slot
    wire logic tk = issue_i && !busy_o;

    property p_skip_busy;
        skip_o |-> busy_o;
    endproperty
    a_skip_busy: assert property (p_skip_busy) else $error("skip without dummy slot");
    property p_busy_one;
        busy_o |=> !busy_o;
    endproperty
    a_busy_one: assert property (p_busy_one) else $error("dummy slot too long");
    property p_busy_quiet;
        busy_o |=> !mem_we_o && !skip_o && $stable(acc_o) && $stable(flags_o);
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("issue taken in dummy slot");
    property p_set_byte;
        tk && instr_i.op == csbx_pkg::CSBX_OP_SET_BYTE |=>
            mem_we_o && mem_wd_o == 8'hFF && $stable(flags_o);
    endproperty
    a_set_byte: assert property (p_set_byte) else $error("set byte wrong");
    property p_skip_z;
        tk && instr_i.op == csbx_pkg::CSBX_OP_SKIP_Z |=> skip_o == ($past(mem_rd_i) == 8'h00);
    endproperty
    a_skip_z: assert property (p_skip_z) else $error("skip on zero wrong");
    property p_swap_acc;
        tk && instr_i.op == csbx_pkg::CSBX_OP_SWAP_ACC |=>
            acc_o == {$past(mem_rd_i[3:0]), $past(mem_rd_i[7:4])} && !mem_we_o;
    endproperty
    a_swap_acc: assert property (p_swap_acc) else $error("nibble swap wrong");
    property p_rrc;
        tk && instr_i.op == csbx_pkg::CSBX_OP_RRC_ACC |=> !mem_we_o &&
            acc_o == {$past(flags_o.carry), $past(mem_rd_i[7:1])} && flags_o.carry == $past(mem_rd_i[0]);
    endproperty
    a_rrc: assert property (p_rrc) else $error("rotate through carry wrong");
    property p_dec_skip;
        tk && instr_i.op == csbx_pkg::CSBX_OP_DEC_SKIP |=> mem_we_o && $stable(flags_o) &&
            mem_wd_o == $past(mem_rd_i) - 8'h01 && skip_o == (mem_wd_o == 8'h00);
    endproperty
    a_dec_skip: assert property (p_dec_skip) else $error("decrement skip wrong");
    property p_sub_carry;
        tk && instr_i.op == csbx_pkg::CSBX_OP_SUB && !instr_i.use_imm |=>
            flags_o.carry == ($past(mem_rd_i) <= $past(acc_o));
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("carry after subtract wrong");
    c_skip: cover property (skip_o);
    c_ref: cover property (issue_i && busy_o);
    c_wr: cover property (mem_we_o && flags_o.carry_zero_flag);
endmodule // csbx_exec_chk
bind csbx_exec csbx_exec_chk u_chk (.mclk_i(mclk_i), .reset_i(reset_i), .issue_i(issue_i),
    .instr_i(instr_i), .mem_rd_i(mem_rd_i), .acc_o(acc_o), .flags_o(flags_o),
    .mem_we_o(mem_we_o), .mem_wd_o(mem_wd_o), .skip_o(skip_o), .busy_o(busy_o));
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic mclk_i, reset_i, issue_i, mem_we_o, skip_o, busy_o;
    logic [7:0] mem_rd_i, acc_o, mem_wd_o, ea;
    csbx_pkg::csbx_instr_s instr_i;
    csbx_pkg::csbx_flags_s flags_o, ef;
    int n_fail, n_tests;

    csbx_exec uut (.mclk_i(mclk_i), .reset_i(reset_i), .issue_i(issue_i), .instr_i(instr_i),
        .mem_rd_i(mem_rd_i), .acc_o(acc_o), .flags_o(flags_o), .mem_we_o(mem_we_o),
        .mem_wd_o(mem_wd_o), .skip_o(skip_o), .busy_o(busy_o));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test;
        if (n_fail == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One instruction, then every output judged one cycle later, write data only when a write is expected
    task automatic go(input csbx_pkg::csbx_op_e op, input logic [7:0] m, input logic [7:0] im,
            input logic ui, input logic [2:0] bs, input logic we, input logic [7:0] wd,
            input logic sk);
        @(posedge mclk_i);
        issue_i <= 1'b1;
        instr_i <= '{op, ui, im, bs};
        mem_rd_i <= m;
        @(posedge mclk_i);
        issue_i <= 1'b0;
        // Stale byte would hide a late sample
        mem_rd_i <= ~m;
        #1;
        chk("acc", ea, acc_o);
        chk("flags", {2'h0, ef}, {2'h0, flags_o});
        chk("mem_we", {7'h00, we}, {7'h00, mem_we_o});
        if (we)
            chk("mem_wd", wd, mem_wd_o);
        chk("skip", {7'h00, sk}, {7'h00, skip_o});
        chk("busy", {7'h00, sk}, {7'h00, busy_o});
    endtask

    function automatic csbx_pkg::csbx_flags_s sub_f(input logic [7:0] a, input logic [7:0] b,
            input logic bin, input logic ch, output logic [7:0] r);
        csbx_pkg::csbx_flags_s f;
        r = a - b - {7'h00, bin};
        f.carry = {1'b0, a} >= {1'b0, b} + {8'h00, bin};
        f.zero = r == 8'h00;
        f.aux_carry_flag = {1'b0, a[3:0]} >= {1'b0, b[3:0]} + {4'h0, bin};
        f.overflow_flag = (a[7] ^ b[7]) & (r[7] ^ a[7]);
        // True sign: result sign bit, flipped when overflow wrapped it
        f.signed_carry_flag = r[7] ^ f.overflow_flag;
        f.carry_zero_flag = ch ? f.zero & ef.zero : f.zero;
        return f;
    endfunction

    task automatic t_rrc;
        ea = 8'h40;
        ef.carry = 1'b1;
        go(csbx_pkg::CSBX_OP_RRC_ACC, 8'h81, 8'h00, 1'b0, 3'h0, 1'b0, 8'h00, 1'b0);
        ea = 8'h81;
        ef.carry = 1'b0;
        go(csbx_pkg::CSBX_OP_RRC_ACC, 8'h02, 8'h00, 1'b0, 3'h0, 1'b0, 8'h00, 1'b0);
    endtask

    // Order matters: zero results first so the chained zero flag is seen set
    task automatic t_sub;
        logic [7:0] ta [5] = '{8'h50, 8'h10, 8'h80, 8'h7F, 8'h13};
        logic [7:0] tv [5] = '{8'h50, 8'h20, 8'h01, 8'hFF, 8'h04};
        csbx_pkg::csbx_op_e ops [6] = '{csbx_pkg::CSBX_OP_SUB, csbx_pkg::CSBX_OP_SUB,
            csbx_pkg::CSBX_OP_SUB_MEM, csbx_pkg::CSBX_OP_SUB_BORROW,
            csbx_pkg::CSBX_OP_SUB_BORROW, csbx_pkg::CSBX_OP_SUB_BORROW_MEM};
        logic [7:0] r;
        logic ui, md, ch;
        for (int i = 0; i < 5; i++) begin
            for (int k = 0; k < 6; k++) begin
                ea = ta[i];
                go(csbx_pkg::CSBX_OP_SKIP_Z_MOVE, ta[i], 8'h00, 1'b0, 3'h0, 1'b0, 8'h00, 1'b0);
                ui = (k == 1 || k == 4);
                md = (k == 2 || k == 5);
                ch = (k >= 3);
                ef = sub_f(ta[i], tv[i], ch & ~ef.carry, ch, r);
                if (!md)
                    ea = r;
                go(ops[k], ui ? ~tv[i] : tv[i], ui ? tv[i] : ~tv[i], ui, 3'h0, md, r, 1'b0);
            end
        end
    endtask

    task automatic sk(input csbx_pkg::csbx_op_e op, input logic [7:0] m, input logic [2:0] bs,
            input logic [7:0] r, input logic s);
        logic w;
        w = op inside {csbx_pkg::CSBX_OP_DEC_SKIP, csbx_pkg::CSBX_OP_INC_SKIP,
            csbx_pkg::CSBX_OP_SET_BYTE, csbx_pkg::CSBX_OP_SET_BIT, csbx_pkg::CSBX_OP_SWAP};
        if (op inside {csbx_pkg::CSBX_OP_DEC_SKIP_ACC, csbx_pkg::CSBX_OP_INC_SKIP_ACC,
                csbx_pkg::CSBX_OP_SKIP_Z_MOVE, csbx_pkg::CSBX_OP_SWAP_ACC})
            ea = r;
        go(op, m, 8'h00, 1'b0, bs, w, r, s);
    endtask

    task automatic t_skip;
        sk(csbx_pkg::CSBX_OP_DEC_SKIP, 8'h01, 3'h0, 8'h00, 1'b1);
        sk(csbx_pkg::CSBX_OP_DEC_SKIP, 8'h00, 3'h0, 8'hFF, 1'b0);
        sk(csbx_pkg::CSBX_OP_DEC_SKIP_ACC, 8'h01, 3'h0, 8'h00, 1'b1);
        sk(csbx_pkg::CSBX_OP_INC_SKIP, 8'hFF, 3'h0, 8'h00, 1'b1);
        sk(csbx_pkg::CSBX_OP_INC_SKIP, 8'h7F, 3'h0, 8'h80, 1'b0);
        sk(csbx_pkg::CSBX_OP_INC_SKIP_ACC, 8'h0F, 3'h0, 8'h10, 1'b0);
        sk(csbx_pkg::CSBX_OP_SKIP_NZ, 8'h00, 3'h0, 8'h00, 1'b0);
        sk(csbx_pkg::CSBX_OP_SKIP_NZ, 8'h10, 3'h0, 8'h00, 1'b1);
        sk(csbx_pkg::CSBX_OP_SKIP_NZ_BIT, 8'h08, 3'h3, 8'h00, 1'b1);
        sk(csbx_pkg::CSBX_OP_SKIP_NZ_BIT, 8'hF7, 3'h3, 8'h00, 1'b0);
        sk(csbx_pkg::CSBX_OP_SKIP_Z, 8'h00, 3'h0, 8'h00, 1'b1);
        sk(csbx_pkg::CSBX_OP_SKIP_Z, 8'h80, 3'h0, 8'h00, 1'b0);
        sk(csbx_pkg::CSBX_OP_SKIP_Z_MOVE, 8'h5A, 3'h0, 8'h5A, 1'b0);
        sk(csbx_pkg::CSBX_OP_SKIP_Z_BIT, 8'hFE, 3'h0, 8'h00, 1'b1);
        sk(csbx_pkg::CSBX_OP_SKIP_Z_BIT, 8'h01, 3'h0, 8'h00, 1'b0);
        sk(csbx_pkg::CSBX_OP_SET_BYTE, 8'h12, 3'h0, 8'hFF, 1'b0);
        sk(csbx_pkg::CSBX_OP_SET_BIT, 8'h00, 3'h7, 8'h80, 1'b0);
        sk(csbx_pkg::CSBX_OP_SET_BIT, 8'h5A, 3'h0, 8'h5B, 1'b0);
        sk(csbx_pkg::CSBX_OP_SWAP, 8'hA5, 3'h0, 8'h5A, 1'b0);
        sk(csbx_pkg::CSBX_OP_SWAP_ACC, 8'h3C, 3'h0, 8'hC3, 1'b0);
    endtask

    // Issue held through the dummy slot must be dropped
    task automatic t_ref;
        @(posedge mclk_i);
        issue_i <= 1'b1;
        instr_i <= '{csbx_pkg::CSBX_OP_SKIP_Z, 1'b0, 8'h00, 3'h0};
        mem_rd_i <= 8'h00;
        @(posedge mclk_i);
        instr_i.op <= csbx_pkg::CSBX_OP_SET_BYTE;
        @(posedge mclk_i);
        issue_i <= 1'b0;
        #1;
        chk("refused", 8'h00, {7'h00, mem_we_o});
    endtask

    initial begin
        repeat (2000) @(posedge mclk_i);
        n_fail++;
        stop_test();
    end

    initial begin
        reset_i = 1'b1;
        issue_i = 1'b0;
        instr_i = '0;
        mem_rd_i = 8'h00;
        ea = 8'h00;
        ef = '0;
        repeat (20) @(posedge mclk_i);
        reset_i <= 1'b0;
        t_rrc();
        t_sub();
        t_skip();
        t_ref();
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
